/* File: stc_consts.vh */
// Constants for the signal trigger and capture block
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH
`define STC_CLK_MHZ        100
`define STC_SMP_RATE_HZ    500000
`define STC_SMP_DIV        (100000000 / `STC_SMP_RATE_HZ)
`define STC_TS_MHZ         84
`define STC_DATA_W         12
`define STC_BUF_DEPTH      1024
`define STC_TS_W           32
`define STC_CH_CNT         3
`define STC_PRI_PPS        2'h1
`define STC_PRI_THR        2'h2
`define STC_PRI_NONE       2'h0
`endif

/* File: stc_skid_buf.v */
// Two-entry valid/ready buffer for one converter sample triple
`timescale 1ns/1ps
`default_nettype none
module stc_skid_buf #(
    parameter W = 36
) (
    input  wire         core_clk,
    input  wire         rstn,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);
    reg [W-1:0] mem_ff [0:1];
    reg         wptr_ff;
    reg         rptr_ff;
    reg [1:0]   cnt_ff;
    wire        push = in_valid && in_ready;
    wire        pop  = out_valid && out_ready;

    assign in_ready  = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = mem_ff[rptr_ff];

    always @(posedge core_clk) begin
        if (push) begin
            mem_ff[wptr_ff] <= in_data;
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wptr_ff <= 1'b0;
            rptr_ff <= 1'b0;
            cnt_ff  <= 2'h0;
        end else begin
            if (push) begin
                wptr_ff <= ~wptr_ff;
            end
            if (pop) begin
                rptr_ff <= ~rptr_ff;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end
endmodule // stc_skid_buf
`default_nettype wire

/* File: stc_capture.v */
// Sample acquisition, circular buffer, threshold trigger and pulse timestamp
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"
module stc_capture #(
    parameter DW      = `STC_DATA_W,
    parameter DEPTH   = `STC_BUF_DEPTH,
    parameter AW      = 10,
    parameter SMP_DIV = `STC_SMP_DIV
) (
    input  wire              core_clk,
    input  wire              rstn,
    input  wire              ts_clk_en,
    input  wire [DW-1:0]     adc_ch0,
    input  wire [DW-1:0]     adc_ch1,
    input  wire [DW-1:0]     adc_ch2,
    input  wire [DW-1:0]     thr_ch0,
    input  wire [DW-1:0]     thr_ch1,
    input  wire [DW-1:0]     thr_ch2,
    input  wire              pps_pin,
    input  wire [AW-1:0]     rd_addr,
    output reg  [3*DW-1:0]   rd_data,
    output wire [AW-1:0]     wr_ptr,
    output wire [`STC_TS_W-1:0] ts_now,
    output wire [`STC_TS_W-1:0] pps_stamp,
    output wire [`STC_TS_W-1:0] trig_stamp,
    output wire [`STC_TS_W-1:0] trig_offset,
    output wire [2:0]        trig_chan,
    output wire              irq_req,
    output wire [1:0]        irq_src,
    input  wire              ack_pps,
    input  wire              ack_thr,
    output wire              overrun
);
    localparam TW = `STC_TS_W;
    localparam DIVW = 16;

    ////////////////////////////////////////////////////////////////////////
    // Converter inputs are asynchronous to core_clk. A word is only safe if it
    // holds steady around the sampling edge; one caught mid-change can tear.
    reg [3*DW-1:0] adc_s1_ff;
    reg [3*DW-1:0] adc_s2_ff;
    reg [2:0]      pps_sync_ff;
    reg [DIVW-1:0] div_ff;
    reg [3*DW-1:0] result_ff;
    reg            result_vld_ff;
    wire           smp_tick = (div_ff == SMP_DIV[DIVW-1:0] - 16'h0001);

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            adc_s1_ff     <= {3*DW{1'b0}};
            adc_s2_ff     <= {3*DW{1'b0}};
            div_ff        <= {DIVW{1'b0}};
            result_ff     <= {3*DW{1'b0}};
            result_vld_ff <= 1'b0;
        end else begin
            adc_s1_ff   <= {adc_ch2, adc_ch1, adc_ch0};
            adc_s2_ff   <= adc_s1_ff;
            div_ff      <= smp_tick ? {DIVW{1'b0}} : div_ff + 16'h0001;
            result_vld_ff <= smp_tick;
            if (smp_tick) begin
                result_ff <= adc_s2_ff;
            end
        end
    end

    // Pulse pin: two flops, the third holds the previous level for the edge
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pps_sync_ff <= 3'h0;
        end else begin
            pps_sync_ff <= {pps_sync_ff[1:0], pps_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer decouples results from memory writes; a missed word is flagged
    wire [3*DW-1:0] bf_data;
    wire            bf_valid;
    wire            bf_in_ready;
    reg             mem_ready_ff;
    reg             overrun_ff;

    stc_skid_buf #(
        .W (3*DW)
    ) u_buf (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_data   (result_ff),
        .in_valid  (result_vld_ff),
        .in_ready  (bf_in_ready),
        .out_data  (bf_data),
        .out_valid (bf_valid),
        .out_ready (mem_ready_ff)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine: one triple per beat into circular memory
    reg [3*DW-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]   wptr_ff;

    always @(posedge core_clk) begin
        if (bf_valid && mem_ready_ff) begin
            mem_ff[wptr_ff] <= bf_data;
        end
        // Read port answers one cycle after the address
        rd_data <= mem_ff[rd_addr];
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wptr_ff      <= {AW{1'b0}};
            mem_ready_ff <= 1'b0;
            overrun_ff   <= 1'b0;
        end else begin
            // The memory port stalls only in the first cycle after reset, so the buffer drains every beat after that
            mem_ready_ff <= 1'b1;
            if (bf_valid && mem_ready_ff) begin
                wptr_ff <= (wptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                             : wptr_ff + 1'b1;
            end
            if (result_vld_ff && !bf_in_ready) begin
                overrun_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timestamp timer advances on the 84 MHz-rate enable
    reg  [TW-1:0] ts_ff;
    reg  [TW-1:0] pps_stamp_ff;
    reg  [TW-1:0] trig_stamp_ff;
    reg  [TW-1:0] trig_offset_ff;
    reg  [2:0]    trig_chan_ff;
    reg           pps_pend_ff;
    reg           thr_pend_ff;
    reg  [2:0]    hit;
    wire          pps_rise = pps_sync_ff[1] && !pps_sync_ff[2];
    wire          trig_take;
    wire [TW-1:0] nxt_pps_stamp;
    wire [TW-1:0] nxt_trig_stamp;

    function reached;
        input [DW-1:0] smp;
        input [DW-1:0] thr;
        begin
            reached = (smp >= thr);
        end
    endfunction

    always @* begin
        hit[0] = reached(result_ff[DW-1:0], thr_ch0);
        hit[1] = reached(result_ff[2*DW-1:DW], thr_ch1);
        hit[2] = reached(result_ff[3*DW-1:2*DW], thr_ch2);
    end

    // A trigger held pending keeps its first stamp until acknowledged
    assign trig_take      = result_vld_ff && (|hit) && (!thr_pend_ff || ack_thr);
    assign nxt_pps_stamp  = pps_rise ? ts_ff : pps_stamp_ff;
    assign nxt_trig_stamp = trig_take ? ts_ff : trig_stamp_ff;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ts_ff <= {TW{1'b0}};
        end else if (ts_clk_en) begin
            ts_ff <= ts_ff + {{(TW-1){1'b0}}, 1'b1};
        end
    end

    // A new edge or hit beats an acknowledge in the same cycle
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pps_stamp_ff   <= {TW{1'b0}};
            trig_stamp_ff  <= {TW{1'b0}};
            trig_offset_ff <= {TW{1'b0}};
            trig_chan_ff   <= 3'h0;
            pps_pend_ff    <= 1'b0;
            thr_pend_ff    <= 1'b0;
        end else begin
            pps_stamp_ff <= nxt_pps_stamp;
            if (pps_rise) begin
                pps_pend_ff <= 1'b1;
            end else if (ack_pps) begin
                pps_pend_ff <= 1'b0;
            end
            trig_stamp_ff <= nxt_trig_stamp;
            if (trig_take) begin
                trig_chan_ff <= hit;
                thr_pend_ff  <= 1'b1;
            end else if (ack_thr) begin
                thr_pend_ff <= 1'b0;
            end
            // Built from the next stamps, so it always matches the two stamp outputs
            trig_offset_ff <= nxt_trig_stamp - nxt_pps_stamp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse capture outranks a pending threshold request; both stay pending
    assign irq_req = pps_pend_ff | thr_pend_ff;
    assign irq_src = pps_pend_ff ? `STC_PRI_PPS :
                     thr_pend_ff ? `STC_PRI_THR : `STC_PRI_NONE;
    assign trig_offset = trig_offset_ff;
    assign wr_ptr      = wptr_ff;
    assign ts_now      = ts_ff;
    assign pps_stamp   = pps_stamp_ff;
    assign trig_stamp  = trig_stamp_ff;
    assign trig_chan   = trig_chan_ff;
    assign overrun     = overrun_ff;
endmodule // stc_capture
`default_nettype wire

/* File: stc_capture_asserts.sv */
// Port checker for the capture block
`timescale 1ns/1ps
`default_nettype none
module stc_capture_chk #(
    parameter AW      = 10,
    parameter SMP_DIV = 200
) (
    input wire logic          core_clk,
    input wire logic          rstn,
    input wire logic          ts_clk_en,
    input wire logic          pps_pin,
    input wire logic [AW-1:0] wr_ptr,
    input wire logic [31:0]   ts_now,
    input wire logic [31:0]   pps_stamp,
    input wire logic [31:0]   trig_stamp,
    input wire logic [31:0]   trig_offset,
    input wire logic [2:0]    trig_chan,
    input wire logic          irq_req,
    input wire logic [1:0]    irq_src,
    input wire logic          overrun
);
    localparam int GAP = SMP_DIV + 8;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_req_src_tie: assert property (irq_req == (irq_src != 2'h0) && irq_src != 2'h3)
        else $error("request and source disagree");
    a_pps_to_irq: assert property ($rose(pps_pin) |-> ##[2:6] irq_src == 2'h1)
        else $error("pulse not flagged");
    a_stamp_new: assert property ($changed(pps_stamp) |-> irq_src == 2'h1)
        else $error("stamp moved without pulse");
    a_ts_step: assert property (1 |=> ts_now == $past(ts_now) + {31'h0, $past(ts_clk_en)})
        else $error("timer step wrong");
    a_offset_diff: assert property (trig_offset == trig_stamp - pps_stamp)
        else $error("offset wrong");
    a_wr_step: assert property ($changed(wr_ptr) |-> wr_ptr == $past(wr_ptr) + 1'b1)
        else $error("pointer jump");
    a_wr_gap: assert property ($changed(wr_ptr) |=> $stable(wr_ptr) [*8])
        else $error("writes too close");
    a_wr_alive: assert property (1 |-> ##[0:GAP] $changed(wr_ptr))
        else $error("writes stopped");
    a_no_overrun: assert property (!overrun)
        else $error("overrun");
    a_trig_cause: assert property ($changed(trig_stamp) |-> trig_chan != 3'h0)
        else $error("trigger without channel");
    c_pps: cover property (irq_src == 2'h1);
    c_thr: cover property (irq_src == 2'h2);
    c_wrap: cover property ($changed(wr_ptr) && wr_ptr == '0);
endmodule // stc_capture_chk
bind stc_capture stc_capture_chk #(.AW(AW), .SMP_DIV(SMP_DIV)) chk_u (.core_clk, .rstn,
    .ts_clk_en, .pps_pin, .wr_ptr, .ts_now, .pps_stamp, .trig_stamp, .trig_offset,
    .trig_chan, .irq_req, .irq_src, .overrun);
`default_nettype wire

/* File: stc_far_end.sv */
// Model of the amplifier channels and the GPS pulse output
`timescale 1ns/1ps
`default_nettype none
module stc_far_end (
    input  wire logic        core_clk,
    output var  logic [11:0] adc_ch0,
    output var  logic [11:0] adc_ch1,
    output var  logic [11:0] adc_ch2,
    output var  logic        pps_pin
);
    initial begin
        {adc_ch2, adc_ch1, adc_ch0} = 36'h0;
        pps_pin = 1'b0;
    end
    task automatic set_lvl(input logic [11:0] a, b, c);
        @(negedge core_clk);
        {adc_ch2, adc_ch1, adc_ch0} = {c, b, a};
    endtask
    // Held well past the pin synchroniser so no edge is lost
    task automatic pulse();
        @(negedge core_clk);
        pps_pin = 1'b1;
        repeat (10) @(negedge core_clk);
        pps_pin = 1'b0;
    endtask
endmodule // stc_far_end
`default_nettype wire

/* File: stc_tb.sv */
// Self-checking bench for the capture block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module testbench;
    localparam int DIV = 20;
    logic        core_clk, rstn = 1'b0, ts_clk_en = 1'b0, pps_pin, irq_req, overrun;
    logic        ack_pps = 1'b0, ack_thr = 1'b0;
    logic [11:0] adc_ch0, adc_ch1, adc_ch2, thr_ch0 = 12'hFFF, thr_ch1 = 12'hFFF;
    logic [11:0] thr_ch2 = 12'hFFF;
    logic [3:0]  rd_addr = 4'h0, wr_ptr;
    logic [35:0] rd_data, smp;
    logic [31:0] ts_now, pps_stamp, trig_stamp, trig_offset, tsv;
    logic [2:0]  trig_chan;
    logic [1:0]  irq_src;
    int          n_errors = 0, checked = 0, cyc = 0, acc = 0;
    stc_capture #(.DEPTH(16), .AW(4), .SMP_DIV(DIV)) dut_u (.core_clk, .rstn, .ts_clk_en,
        .adc_ch0, .adc_ch1, .adc_ch2, .thr_ch0, .thr_ch1, .thr_ch2, .pps_pin, .rd_addr,
        .rd_data, .wr_ptr, .ts_now, .pps_stamp, .trig_stamp, .trig_offset, .trig_chan,
        .irq_req, .irq_src, .ack_pps, .ack_thr, .overrun);
    stc_far_end far_u (.core_clk, .adc_ch0, .adc_ch1, .adc_ch2, .pps_pin);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Timer enable: 84 pulses in every 100 cycles
    always @(negedge core_clk) begin
        acc = acc + 84;
        ts_clk_en = (acc >= 100);
        if (acc >= 100) acc = acc - 100;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic tick(input int n);
        logic [3:0] p;
        repeat (n) begin
            p = wr_ptr;
            for (int i = 0; i < 3 * DIV && wr_ptr === p; i++) @(negedge core_clk);
        end
    endtask
    task automatic rd(input logic [3:0] a);
        rd_addr = a;
        @(negedge core_clk);
        smp = rd_data;
    endtask
    task automatic ack(input logic p, t);
        {ack_pps, ack_thr} = {p, t};
        @(negedge core_clk);
        {ack_pps, ack_thr} = 2'b00;
        @(negedge core_clk);
    endtask
    task automatic wait_src(input logic [1:0] s);
        for (int i = 0; i < 50 && irq_src !== s; i++) @(negedge core_clk);
    endtask
    task automatic t_stream();
        int t0;
        far_u.set_lvl(12'h123, 12'h456, 12'h789);
        tick(3);
        rd(wr_ptr - 1'b1);
        `CHK(smp, 36'h789456123)
        tick(1);
        t0 = cyc;
        tick(1);
        `CHK(cyc - t0, DIV)
        tsv = ts_now;
        repeat (100) @(negedge core_clk);
        `CHK(ts_now - tsv, 32'h54)
        $display("stream done");
    endtask
    task automatic t_thr();
        far_u.pulse();
        wait_src(2'h1);
        `CHK(irq_src, 2'h1)
        ack(1'b1, 1'b0);
        `CHK(irq_req, 1'b0)
        thr_ch1 = 12'h456;  // Equal level must trigger too
        wait_src(2'h2);
        thr_ch1 = 12'hFFF;
        `CHK(trig_chan, 3'h2)
        `CHK(trig_offset, trig_stamp - pps_stamp)
        `CHK(ts_now >= trig_stamp, 1'b1)
        rd(wr_ptr - 1'b1);
        `CHK(smp, 36'h789456123)
        far_u.pulse();
        `CHK(irq_src, 2'h1)
        ack(1'b1, 1'b0);
        `CHK(irq_src, 2'h2)
        ack(1'b0, 1'b1);
        `CHK(irq_req, 1'b0)
        $display("trigger done");
    endtask
    task automatic t_wrap();
        logic [3:0] p;
        p = wr_ptr;
        far_u.set_lvl(12'hABC, 12'h0DE, 12'hF01);
        tick(16);
        `CHK(wr_ptr, p)
        rd(p - 1'b1);
        `CHK(smp, 36'hF010DEABC)
        `CHK(overrun, 1'b0)
        $display("wrap done");
    endtask
    task automatic stop_test();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        t_stream();
        t_thr();
        t_wrap();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
